// [common/ssc_map.vh]
// Constants for the serial channel
// Functional notes
// [R1] RTS low when ready, high on receive start
// [R2] Internal clock disables the RTS function
// [R3] Shutdown with cutoff floats clock, RTS, receive pins
// [R4] External clock idles until enable, data, CTS
// [R5] Polarity picks launch and sample edges, idle
// [R6] Shift clock only from transmitter, dummy data out
// [R7] Internal clock starts on enable plus buffer data
// [R8] Peer clocks only after enable and dummy load
// [R9] Word completing while buffer full sets overrun
// [R10] Overrun leaves receive interrupt request unchanged
// [R11] Controller writes one dummy per received word
// [R12] External receive needs both enables, buffer data
// [R13] Deselect condition output, wait before condition request; the channel has no deselect output or wait
// [R14] Smart-card source plus error output raise transmit request
// [R15] Clean receive sets buffer full and request
`ifndef SSC_MAP_VH
`define SSC_MAP_VH
`define SSC_DATA_BITS    8
`define SSC_CLK_HZ       200000000
`define SSC_SHIFT_HZ     1000000
`define SSC_DIV_COUNT    (`SSC_CLK_HZ / (2 * `SSC_SHIFT_HZ))
`define SSC_POL_FALL_TX  1'b0
`define SSC_POL_RISE_TX  1'b1
`define SSC_ST_IDLE      2'h0
`define SSC_ST_SHIFT     2'h1
`endif

// [hdl/ssc_sync2.v]
// Two-flop synchroniser for inputs from outside the clock domain
`timescale 1ns/1ps
module ssc_sync2 (
  // Clock and reset
  input  wire I_CLK,
  input  wire I_RESET_N,
  // Data
  input  wire i_async,
  output reg  o_sync
);
  reg meta_q;
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule

// [hdl/ssc_channel.v]
// Clock synchronous serial channel with RTS, overrun and special-mode requests
`timescale 1ns/1ps
`include "ssc_map.vh"
module ssc_channel #(
  parameter DW      = `SSC_DATA_BITS,
  parameter DIV_CNT = `SSC_DIV_COUNT
) (
  // Clock and reset
  input  wire          I_CLK,
  input  wire          I_RESET_N,
  // Configuration
  input  wire          I_CLOCK_POLARITY_SELECT,
  input  wire          I_EXTERNAL_CLOCK,
  input  wire          I_RTS_ENABLE,
  input  wire          I_CTS_ENABLE,
  input  wire          I_TRANSMIT_ENABLE,
  input  wire          I_RECEIVE_ENABLE,
  input  wire          I_FORCED_CUTOFF_ENABLE,
  input  wire          I_SMART_CARD_MODE,
  input  wire          I_TRANSMIT_INTERRUPT_SOURCE_SELECT,
  input  wire          I_ERROR_SIGNAL_OUTPUT_ENABLE,
  // Transmit buffer write and status read-clear
  input  wire          I_TX_WRITE,
  input  wire [DW-1:0] I_TX_DATA,
  input  wire          I_RX_READ,
  input  wire          I_RX_IRQ_CLEAR,
  input  wire          I_TX_IRQ_CLEAR,
  // Pins
  input  wire          I_SHUTDOWN_INPUT_N,
  input  wire          I_SERIAL_CLOCK_PIN,
  input  wire          I_SERIAL_RECEIVE_PIN,
  input  wire          I_CLEAR_TO_SEND_N,
  output reg           O_SERIAL_TRANSMIT_PIN,
  output reg           O_SERIAL_CLOCK_PIN,
  output wire          O_SERIAL_CLOCK_OE,
  output reg           O_REQUEST_TO_SEND_N,
  output wire          O_REQUEST_TO_SEND_OE,
  output wire          O_RECEIVE_PIN_CUTOFF,
  // Status
  output wire          O_TRANSMIT_BUFFER_EMPTY_FLAG,
  output reg           O_RECEIVE_BUFFER_FULL_FLAG,
  output reg           O_OVERRUN_ERROR_FLAG,
  output reg  [DW-1:0] O_RECEIVE_BUFFER,
  output reg           O_RX_INTERRUPT_REQUEST_FLAG,
  output reg           O_TX_INTERRUPT_REQUEST_FLAG
);
  localparam CW = 16;
  localparam BW = 4;

  wire sclk_s, rxd_s, cts_n_s, sd_n_s;
  ssc_sync2 u_sclk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_async(I_SERIAL_CLOCK_PIN), .o_sync(sclk_s));
  ssc_sync2 u_rxd  (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_async(I_SERIAL_RECEIVE_PIN), .o_sync(rxd_s));
  ssc_sync2 u_cts  (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_async(I_CLEAR_TO_SEND_N), .o_sync(cts_n_s));
  ssc_sync2 u_sd   (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .i_async(I_SHUTDOWN_INPUT_N), .o_sync(sd_n_s));

  reg          tx_full_q;
  reg [DW-1:0] tx_buf_q;
  reg [DW-1:0] tx_sh_q;
  reg [DW-1:0] rx_sh_q;
  reg [BW-1:0] bit_q;
  reg [1:0]    st_q;
  reg [CW-1:0] div_q;
  reg          sclk_prev_q;
  reg          sce_prev_q;
  reg          int_clk_q;

  wire cutoff     = I_FORCED_CUTOFF_ENABLE & ~sd_n_s;              // [R3]
  wire idle_lvl   = ~I_CLOCK_POLARITY_SELECT;                      // [R5]
  wire cts_ok     = ~I_CTS_ENABLE | ~cts_n_s;
  // Start needs the transmitter armed even for receive-only use
  wire start_ok   = I_TRANSMIT_ENABLE & tx_full_q & cts_ok;        // [R4] [R6] [R7]
  wire ext_ok     = start_ok & I_RECEIVE_ENABLE;                   // [R12]
  wire active     = (st_q == `SSC_ST_SHIFT);

  // Internal clock half-period enable
  wire half_tick  = (div_q == DIV_CNT[CW-1:0] - 16'h0001);
  wire clk_now    = I_EXTERNAL_CLOCK ? sclk_s : int_clk_q;
  wire clk_rise   = clk_now & ~sclk_prev_q;
  wire clk_fall   = ~clk_now & sclk_prev_q;
  // Polarity 0: launch on fall, sample on rise; polarity 1 reversed
  wire launch_e   = I_CLOCK_POLARITY_SELECT ? clk_rise : clk_fall; // [R5]
  wire sample_e   = I_CLOCK_POLARITY_SELECT ? clk_fall : clk_rise; // [R5]
  wire last_bit   = (bit_q == DW[BW-1:0] - 4'h1);
  wire word_done  = active & sample_e & last_bit;
  wire [DW-1:0] rx_word = {rxd_s, rx_sh_q[DW-1:1]};
  wire overrun    = word_done & O_RECEIVE_BUFFER_FULL_FLAG;        // [R9]

  assign O_TRANSMIT_BUFFER_EMPTY_FLAG = ~tx_full_q;
  assign O_SERIAL_CLOCK_OE    = ~I_EXTERNAL_CLOCK & ~cutoff;       // [R3]
  // RTS has no meaning with an internal clock
  assign O_REQUEST_TO_SEND_OE = I_RTS_ENABLE & I_EXTERNAL_CLOCK & ~cutoff; // [R2] [R3]
  assign O_RECEIVE_PIN_CUTOFF = cutoff;                            // [R3]

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      div_q       <= 16'h0000;
      int_clk_q   <= 1'b1;
      sclk_prev_q <= 1'b1;
    end else begin
      sclk_prev_q <= clk_now;
      if (I_EXTERNAL_CLOCK || !active) begin
        div_q     <= 16'h0000;
        int_clk_q <= idle_lvl;                                     // [R5]
      end else if (half_tick) begin
        div_q     <= 16'h0000;
        int_clk_q <= ~int_clk_q;
      end else begin
        div_q     <= div_q + 16'h0001;
      end
    end
  end

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_SERIAL_CLOCK_PIN <= 1'b1;
    end else begin
      O_SERIAL_CLOCK_PIN <= int_clk_q;                             // [R6]
    end
  end

  // Transmit buffer; one dummy per received word keeps the clock going
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      tx_full_q <= 1'b0;
      tx_buf_q  <= 8'h00;
    end else begin
      if (I_TX_WRITE) begin
        tx_full_q <= 1'b1;                                         // [R11]
        tx_buf_q  <= I_TX_DATA;
      end else if (!active && (I_EXTERNAL_CLOCK ? ext_ok : start_ok)) begin
        tx_full_q <= 1'b0;
      end
    end
  end

  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      st_q                  <= `SSC_ST_IDLE;
      bit_q                 <= 4'h0;
      tx_sh_q               <= 8'h00;
      rx_sh_q               <= 8'h00;
      O_SERIAL_TRANSMIT_PIN <= 1'b1;
      sce_prev_q            <= 1'b0;
    end else begin
      sce_prev_q <= active;
      case (st_q)
        `SSC_ST_IDLE: begin
          bit_q <= 4'h0;
          if (!I_TX_WRITE && (I_EXTERNAL_CLOCK ? ext_ok : start_ok)) begin // [R4] [R7] [R12]
            st_q                  <= `SSC_ST_SHIFT;
            tx_sh_q               <= {1'b1, tx_buf_q[DW-1:1]};
            O_SERIAL_TRANSMIT_PIN <= tx_buf_q[0];                  // [R6]
          end
        end
        `SSC_ST_SHIFT: begin
          if (sample_e) begin
            rx_sh_q <= rx_word;
            bit_q   <= bit_q + 4'h1;
            if (last_bit) begin
              st_q <= `SSC_ST_IDLE;
            end
          end
          if (launch_e && bit_q != 4'h0) begin
            O_SERIAL_TRANSMIT_PIN <= tx_sh_q[0];
            tx_sh_q               <= {1'b1, tx_sh_q[DW-1:1]};
          end
        end
        default: st_q <= `SSC_ST_IDLE;
      endcase
    end
  end

  // RTS: low while ready, high once a receive begins
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_REQUEST_TO_SEND_N <= 1'b1;
    end else if (!(I_RTS_ENABLE && I_EXTERNAL_CLOCK)) begin
      O_REQUEST_TO_SEND_N <= 1'b1;                                 // [R2]
    end else if (active) begin
      O_REQUEST_TO_SEND_N <= 1'b1;                                 // [R1]
    end else begin
      O_REQUEST_TO_SEND_N <= ~(I_RECEIVE_ENABLE & ~O_RECEIVE_BUFFER_FULL_FLAG); // [R1]
    end
  end

  // Receive side: set wins over read and clear
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_RECEIVE_BUFFER_FULL_FLAG  <= 1'b0;
      O_OVERRUN_ERROR_FLAG        <= 1'b0;
      O_RECEIVE_BUFFER            <= 8'h00;
      O_RX_INTERRUPT_REQUEST_FLAG <= 1'b0;
    end else begin
      if (word_done) begin
        O_RECEIVE_BUFFER           <= rx_word;                     // [R9]
        O_RECEIVE_BUFFER_FULL_FLAG <= 1'b1;                        // [R15]
      end else if (I_RX_READ) begin
        O_RECEIVE_BUFFER_FULL_FLAG <= 1'b0;
      end
      if (overrun) begin
        O_OVERRUN_ERROR_FLAG <= 1'b1;                              // [R9]
      end else if (I_RX_READ) begin
        O_OVERRUN_ERROR_FLAG <= 1'b0;
      end
      if (word_done && !overrun) begin
        O_RX_INTERRUPT_REQUEST_FLAG <= 1'b1;                       // [R15] [R10]
      end else if (I_RX_IRQ_CLEAR) begin
        O_RX_INTERRUPT_REQUEST_FLAG <= 1'b0;
      end
    end
  end

  // Transmit request: end of word, or smart-card source plus error output
  always @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      O_TX_INTERRUPT_REQUEST_FLAG <= 1'b0;
    end else if ((sce_prev_q && !active) ||
                 (I_SMART_CARD_MODE && I_TRANSMIT_INTERRUPT_SOURCE_SELECT && I_ERROR_SIGNAL_OUTPUT_ENABLE)) begin
      O_TX_INTERRUPT_REQUEST_FLAG <= 1'b1;                         // [R14]
    end else if (I_TX_IRQ_CLEAR) begin
      O_TX_INTERRUPT_REQUEST_FLAG <= 1'b0;
    end
  end
endmodule

// [verif/ssc_channel_assertions.sv]
// Port assertions for the serial channel
`timescale 1ns/1ps
module ssc_channel_assertions (
  input wire logic I_CLK, I_RESET_N, I_CLOCK_POLARITY_SELECT, I_EXTERNAL_CLOCK, I_TRANSMIT_ENABLE, I_TX_WRITE,
  input wire logic I_CTS_ENABLE, I_RTS_ENABLE, I_SHUTDOWN_INPUT_N, I_FORCED_CUTOFF_ENABLE, I_SMART_CARD_MODE,
  input wire logic I_TRANSMIT_INTERRUPT_SOURCE_SELECT, I_ERROR_SIGNAL_OUTPUT_ENABLE, O_SERIAL_CLOCK_PIN,
  input wire logic O_SERIAL_CLOCK_OE, O_REQUEST_TO_SEND_N, O_REQUEST_TO_SEND_OE, O_RECEIVE_PIN_CUTOFF,
  input wire logic O_TRANSMIT_BUFFER_EMPTY_FLAG, O_RECEIVE_BUFFER_FULL_FLAG, O_OVERRUN_ERROR_FLAG,
  input wire logic O_RX_INTERRUPT_REQUEST_FLAG, O_TX_INTERRUPT_REQUEST_FLAG
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  sequence load_s;
    $rose(I_TX_WRITE) && I_TRANSMIT_ENABLE && !I_EXTERNAL_CLOCK && !I_CTS_ENABLE;
  endsequence
  // Buffer fills, then empties as the word starts; a word in flight may delay it
  sequence word_s;
    ##1 !O_TRANSMIT_BUFFER_EMPTY_FLAG ##[1:60] O_TRANSMIT_BUFFER_EMPTY_FLAG;
  endsequence
  AST_INT_START: assert property (load_s |-> word_s) else $error("word did not start");
  AST_NO_RTS: assert property (!I_EXTERNAL_CLOCK [*2] |-> O_REQUEST_TO_SEND_N) else $error("rts active");
  AST_RTS_BUSY: assert property ((I_EXTERNAL_CLOCK && I_RTS_ENABLE && O_RECEIVE_BUFFER_FULL_FLAG) [*2]
    |-> O_REQUEST_TO_SEND_N) else $error("rts low while full");
  AST_CUTOFF: assert property ((!I_SHUTDOWN_INPUT_N && I_FORCED_CUTOFF_ENABLE) [*4]
    |-> !O_SERIAL_CLOCK_OE && !O_REQUEST_TO_SEND_OE && O_RECEIVE_PIN_CUTOFF) else $error("pins not floated");
  AST_CLK_HOLD: assert property ($fell(O_SERIAL_CLOCK_PIN) && !I_CLOCK_POLARITY_SELECT
    && $stable(I_CLOCK_POLARITY_SELECT) |-> I_TRANSMIT_ENABLE) else $error("clock left idle");
  AST_OVR_CAUSE: assert property ($rose(O_OVERRUN_ERROR_FLAG) |-> $past(O_RECEIVE_BUFFER_FULL_FLAG))
    else $error("overrun without full buffer");
  AST_OVR_IRQ: assert property ($rose(O_OVERRUN_ERROR_FLAG) |-> $stable(O_RX_INTERRUPT_REQUEST_FLAG))
    else $error("overrun moved rx request");
  AST_RX_SET: assert property ($rose(O_RECEIVE_BUFFER_FULL_FLAG) |-> O_RX_INTERRUPT_REQUEST_FLAG
    && !O_OVERRUN_ERROR_FLAG) else $error("clean receive flags");
  AST_SC_IRQ: assert property (I_SMART_CARD_MODE && I_TRANSMIT_INTERRUPT_SOURCE_SELECT
    && I_ERROR_SIGNAL_OUTPUT_ENABLE |=> O_TX_INTERRUPT_REQUEST_FLAG) else $error("no tx request");
endmodule
bind ssc_channel ssc_channel_assertions i_chk (.*);

// [verif/ssc_peer_model.sv]
// Far-side peer: supplies the external shift clock and the receive data
`timescale 1ns/1ps
module ssc_peer_model (
  input  wire logic       i_pol,
  input  wire logic       i_go,
  input  wire logic [7:0] i_byte,
  output wire logic       o_sclk,
  output logic            o_sdata
);
  logic busy = 1'h0;
  logic ph = 1'h0;
  // Clock stands at the idle level outside frames
  assign o_sclk = busy ? ph : !i_pol;
  initial o_sdata = 1'h0;
  // Go comes only after both enables are set and a dummy word is loaded
  always begin
    wait (i_go);
    ph = i_pol;
    busy = 1'h1;
    for (int k = 0; k < 8; k++) begin
      ph = i_pol;
      o_sdata = i_byte[k];
      #32;
      ph = !i_pol;
      #32;
    end
    busy = 1'h0;
    // Line no longer held and has no pull, so it shows the inverse
    o_sdata = !i_byte[7];
    wait (!i_go);
  end
endmodule

// [verif/tb_top.sv]
// Self-checking bench for the serial channel
`timescale 1ns/1ps
module tb_top;
  logic I_CLK, I_RESET_N, I_CLOCK_POLARITY_SELECT, I_EXTERNAL_CLOCK, I_RTS_ENABLE, I_CTS_ENABLE, I_TX_WRITE, go;
  logic I_TRANSMIT_ENABLE, I_RECEIVE_ENABLE, I_FORCED_CUTOFF_ENABLE, I_SMART_CARD_MODE, I_RX_READ;
  logic I_TRANSMIT_INTERRUPT_SOURCE_SELECT, I_ERROR_SIGNAL_OUTPUT_ENABLE, I_RX_IRQ_CLEAR, I_TX_IRQ_CLEAR;
  logic I_SHUTDOWN_INPUT_N, I_CLEAR_TO_SEND_N, O_SERIAL_TRANSMIT_PIN, O_SERIAL_CLOCK_PIN, O_SERIAL_CLOCK_OE;
  logic O_REQUEST_TO_SEND_N, O_REQUEST_TO_SEND_OE, O_RECEIVE_PIN_CUTOFF, O_TRANSMIT_BUFFER_EMPTY_FLAG;
  logic O_RECEIVE_BUFFER_FULL_FLAG, O_OVERRUN_ERROR_FLAG, O_RX_INTERRUPT_REQUEST_FLAG, O_TX_INTERRUPT_REQUEST_FLAG;
  logic [7:0] I_TX_DATA, O_RECEIVE_BUFFER, pbyte;
  wire        I_SERIAL_CLOCK_PIN, I_SERIAL_RECEIVE_PIN, p_sdata;
  int         errors, n_tests;
  // Three cycles per half period leave room for the two-flop loopback delay
  ssc_channel #(.DIV_CNT(3)) i_dut (.*);
  ssc_peer_model i_peer (.i_pol(I_CLOCK_POLARITY_SELECT), .i_go(go), .i_byte(pbyte),
                         .o_sclk(I_SERIAL_CLOCK_PIN), .o_sdata(p_sdata));
  // Internal clock runs as a loopback, so the sent word must come back
  assign I_SERIAL_RECEIVE_PIN = I_EXTERNAL_CLOCK ? p_sdata : O_SERIAL_TRANSMIT_PIN;
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge I_CLK);
    #1;
  endtask
  task automatic send(logic [7:0] d);
    @(posedge I_CLK);
    I_TX_WRITE <= 1'h1;
    I_TX_DATA <= d;
    @(posedge I_CLK);
    I_TX_WRITE <= 1'h0;
  endtask
  task automatic ack(logic rd);
    @(posedge I_CLK);
    {I_RX_READ, I_RX_IRQ_CLEAR, I_TX_IRQ_CLEAR} <= {rd, 2'h3};
    @(posedge I_CLK);
    {I_RX_READ, I_RX_IRQ_CLEAR, I_TX_IRQ_CLEAR} <= 3'h0;
  endtask
  task automatic wait_on(logic ovr);
    for (int k = 0; k < 400 && (ovr ? O_OVERRUN_ERROR_FLAG : O_RECEIVE_BUFFER_FULL_FLAG) !== 1'h1; k++) cyc(1);
  endtask
  task automatic t_internal;
    send(8'hA5);
    cyc(80);
    chk("held", 8'h00, O_TRANSMIT_BUFFER_EMPTY_FLAG);
    @(posedge I_CLK);
    I_TRANSMIT_ENABLE <= 1'h1;
    wait_on(1'h0);
    chk("rx_data", 8'hA5, O_RECEIVE_BUFFER);
    chk("rx_irq", 8'h01, O_RX_INTERRUPT_REQUEST_FLAG);
    ack(1'h1);
    cyc(4);
    chk("rts_off", 8'h01, O_REQUEST_TO_SEND_N);
    $display("t_internal done");
  endtask
  task automatic t_overrun;
    send(8'h11);
    cyc(3);
    send(8'h22);
    wait_on(1'h0);
    ack(1'h0);
    wait_on(1'h1);
    chk("ovr", 8'h01, O_OVERRUN_ERROR_FLAG);
    chk("ovr_irq", 8'h00, O_RX_INTERRUPT_REQUEST_FLAG);
    ack(1'h1);
    $display("t_overrun done");
  endtask
  task automatic t_external;
    @(posedge I_CLK);
    {I_EXTERNAL_CLOCK, I_CLOCK_POLARITY_SELECT} <= 2'h3;
    pbyte <= 8'h3C;
    cyc(6);
    chk("rts_ready", 8'h00, O_REQUEST_TO_SEND_N);
    send(8'h00);
    go <= 1'h1;
    wait_on(1'h0);
    chk("ext_data", 8'h3C, O_RECEIVE_BUFFER);
    chk("rts_busy", 8'h01, O_REQUEST_TO_SEND_N);
    go <= 1'h0;
    ack(1'h1);
    @(posedge I_CLK);
    {I_EXTERNAL_CLOCK, I_CLOCK_POLARITY_SELECT} <= 2'h0;
    $display("t_external done");
  endtask
  task automatic t_cutoff;
    @(posedge I_CLK);
    {I_FORCED_CUTOFF_ENABLE, I_SHUTDOWN_INPUT_N} <= 2'h2;
    cyc(4);
    chk("cutoff", 8'h01, {O_SERIAL_CLOCK_OE, O_REQUEST_TO_SEND_OE, O_RECEIVE_PIN_CUTOFF});
    @(posedge I_CLK);
    I_SHUTDOWN_INPUT_N <= 1'h1;
    cyc(4);
    chk("clk_oe", 8'h01, O_SERIAL_CLOCK_OE);
    $display("t_cutoff done");
  endtask
  task automatic t_smart(logic [2:0] bits, logic [7:0] exp);
    @(posedge I_CLK);
    {I_SMART_CARD_MODE, I_TRANSMIT_INTERRUPT_SOURCE_SELECT, I_ERROR_SIGNAL_OUTPUT_ENABLE} <= bits;
    ack(1'h0);
    cyc(1);
    chk("sc_irq", exp, O_TX_INTERRUPT_REQUEST_FLAG);
    $display("t_smart done");
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    I_CLK = 1'h0;
    forever #2.5 I_CLK = ~I_CLK;
  end
  initial begin
    #40000;
    errors++;
    wrap_up;
  end
  initial begin
    {I_RESET_N, I_CLOCK_POLARITY_SELECT, I_EXTERNAL_CLOCK, I_CTS_ENABLE, I_TX_WRITE, I_TRANSMIT_ENABLE, go} = '0;
    {I_FORCED_CUTOFF_ENABLE, I_SMART_CARD_MODE, I_RX_READ, I_RX_IRQ_CLEAR, I_TX_IRQ_CLEAR, I_CLEAR_TO_SEND_N} = '0;
    {I_TRANSMIT_INTERRUPT_SOURCE_SELECT, I_ERROR_SIGNAL_OUTPUT_ENABLE, I_TX_DATA, pbyte} = '0;
    {I_RTS_ENABLE, I_RECEIVE_ENABLE, I_SHUTDOWN_INPUT_N} = 3'h7;
    errors = 0;
    n_tests = 0;
    repeat (2) @(posedge I_CLK);
    I_RESET_N <= 1'h1;
    cyc(1);
    chk("reset", 8'h1C, {O_SERIAL_TRANSMIT_PIN, O_REQUEST_TO_SEND_N, O_TRANSMIT_BUFFER_EMPTY_FLAG,
                         O_RECEIVE_BUFFER_FULL_FLAG, O_OVERRUN_ERROR_FLAG});
    t_internal;
    t_overrun;
    t_external;
    t_cutoff;
    t_smart(3'h7, 8'h01);
    t_smart(3'h0, 8'h00);
    wrap_up;
  end
endmodule
